// *** rtl/rioh_top.v ***
// device-side handshake and status logic for the single-station remote i/o image
`timescale 1ns/1ps
`include "rioh_regs.vh"
module rioh_top (
  input  wire        clk,
  input  wire        resetn,
  // remote output bits from the master
  input  wire        run_fwd_request,
  input  wire        run_rev_request,
  input  wire        monitor_request,
  input  wire        speed_write_request,
  input  wire        cmd_exec_request,
  input  wire        alarm_clear_request,
  // remote register words from the master
  input  wire [15:0] monitor_code_word,
  input  wire [15:0] speed_command_word,
  input  wire [15:0] command_code_word,
  input  wire [15:0] write_data_word,
  // drive-side status, same clock domain
  input  wire        motor_fwd,
  input  wire        motor_rev,
  input  wire        prot_tripped,
  input  wire        output_stopped,
  input  wire        alarm_raised,
  input  wire        alarm_excluded,
  input  wire        drive_ready,
  input  wire [15:0] monitor_data,
  input  wire [15:0] cmd_read_data,
  input  wire        cmd_data_ok,
  // configuration pins
  input  wire [1:0]  command_source_setting,
  input  wire        link_enable_input,
  input  wire [14:0] terminal_function_sel,
  input  wire [4:0]  speed_flags,
  // drive-side controls
  output reg  [15:0] monitor_code_out,
  output reg  [15:0] speed_ref_r,
  output reg         speed_ref_valid_r,
  output reg  [15:0] cmd_code_out,
  output reg  [15:0] cmd_write_out,
  output reg         cmd_strobe_r,
  output reg         alarm_reset_r,
  output reg         run_fwd_out,
  output reg         run_rev_out,
  // remote input image and registers to the master
  output reg  [15:0] rx_word0_r,
  output reg  [15:0] rx_word1_r,
  output reg  [15:0] monitored_value_word,
  output reg  [15:0] response_code_word,
  output reg  [15:0] read_data_word
);

  // =======================================
  // command source and link enable pins synchronised
  wire [2:0] cfg_s;
  rioh_sync #(.W(3)) u_cfg_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({link_enable_input, command_source_setting}),
    .q      (cfg_s)
  );
  wire       link_en_s = cfg_s[2];
  wire [1:0] csrc_s    = cfg_s[1:0];

  // pins arrive two edges late, so a change of command source or link enable
  // takes hold two cycles after the pin moves; run bits in flight follow it
  // link commands allowed only when source is link and link enabled
  wire link_cmd_ok = link_en_s &&
                     (csrc_s != `RIOH_CSRC_LOCAL0) &&
                     (csrc_s != `RIOH_CSRC_LOCAL1);

  // =======================================
  // terminal source mux, shared by five bits
  // codes above four read zero so a bad setting cannot raise a stray bit
  function term_pick;
    input [2:0] sel;
    input [4:0] flags;
    begin
      case (sel)
        `RIOH_SRC_EXISTS:  term_pick = flags[0];
        `RIOH_SRC_MATCH:   term_pick = flags[1];
        `RIOH_SRC_ARRIVAL: term_pick = flags[2];
        `RIOH_SRC_DETECT1: term_pick = flags[3];
        `RIOH_SRC_READY:   term_pick = flags[4];
        default:           term_pick = 1'b0;
      endcase
    end
  endfunction

  // speed word range check, signed
  function spd_in_range;
    input [15:0] w;
    begin
      spd_in_range = ($signed(w) <= `RIOH_SPD_MAX) && ($signed(w) >= `RIOH_SPD_MIN);
    end
  endfunction

  // =======================================
  // initial setup counter and alarm state
  localparam CW = 7;
  localparam integer  INIT_CYC_I = `RIOH_INIT_CYC;
  localparam [CW-1:0] INIT_CYC   = INIT_CYC_I[CW-1:0];
  reg [CW-1:0] init_cnt_r;
  reg          init_done_r;
  reg          alarm_r;
  wire         alarm_evt = alarm_raised && !alarm_excluded;

  // ready is withheld while the drive settles its initial data; the master
  // uses the ready bit to interlock its reads and writes
  always @(posedge clk) begin
    if (!resetn) begin
      init_cnt_r  <= {CW{1'b0}};
      init_done_r <= 1'b0;
    end else if (!init_done_r) begin
      if (init_cnt_r == INIT_CYC - 1'b1)
        init_done_r <= 1'b1;
      init_cnt_r <= init_cnt_r + 1'b1;
    end
  end

  // set wins: a new alarm in the clearing cycle stays latched
  // a clear held high keeps resetting the drive; the master is expected to
  // drop it once the flag falls, or a later alarm is cleared at once
  always @(posedge clk) begin
    if (!resetn)
      alarm_r <= 1'b0;
    else if (alarm_evt)
      alarm_r <= 1'b1;
    else if (alarm_clear_request)
      alarm_r <= 1'b0;
  end

  // =======================================
  // request edge tracking
  // delayed copy of the monitor request; the flag waits for it so the value word leads
  reg mon_req_d_r;
  always @(posedge clk) begin
    if (!resetn)
      mon_req_d_r <= 1'b0;
    else
      mon_req_d_r <= monitor_request;
  end

  // =======================================
  // handshake flags and data paths
  // latency from a request edge, as the master sees it in the image
  //   monitor: value word after one edge, flag after two, image bit after three
  //   speed:   reference and flag after one edge, image bit after two
  //   command: strobe after one edge, flag after two, image bit after three
  //   alarm:   flag after one edge of the raised input, image after two
  //   ready:   fifty cycles of setup after reset, then one image cycle
  //   the monitor, speed and command flags clear one edge after the request drops, image one later
  // the monitor flag waits for the delayed request so that the value word
  // is already in place when the master sees the flag
  reg mon_flag_r;
  reg spd_flag_r;
  reg cmd_flag_r;

  always @(posedge clk) begin
    // outputs start at zero so the drive sees no command until the master asks
    if (!resetn) begin
      mon_flag_r           <= 1'b0;
      spd_flag_r           <= 1'b0;
      cmd_flag_r           <= 1'b0;
      monitored_value_word <= 16'h0000;
      monitor_code_out     <= 16'h0000;
      speed_ref_r          <= 16'h0000;
      speed_ref_valid_r    <= 1'b0;
      cmd_code_out         <= 16'h0000;
      cmd_write_out        <= 16'h0000;
      cmd_strobe_r         <= 1'b0;
      response_code_word   <= `RIOH_RESP_OK;
      read_data_word       <= 16'h0000;
      alarm_reset_r        <= 1'b0;
      run_fwd_out          <= 1'b0;
      run_rev_out          <= 1'b0;
    end else begin
      // monitor: refresh every cycle while held
      // the code word is passed on every cycle so a new code takes effect at once
      monitor_code_out <= monitor_code_word;
      if (monitor_request) begin
        monitored_value_word <= monitor_data;
        mon_flag_r           <= mon_req_d_r;
      end else begin
        mon_flag_r <= 1'b0;
      end
      // speed: applied continuously, rejected if out of full scale
      // an out-of-range word is refused and the last good reference stays;
      // the done flag still rises so the master is not left waiting
      speed_ref_valid_r <= 1'b0;
      if (speed_write_request) begin
        if (spd_in_range(speed_command_word)) begin
          speed_ref_r       <= speed_command_word;
          speed_ref_valid_r <= link_cmd_ok;
        end
        spd_flag_r <= 1'b1;
      end else begin
        spd_flag_r <= 1'b0;
      end
      // command: strobe each cycle while held, so it repeats
      // the response and read data follow one edge behind the strobe, so the
      // command unit has a full cycle to settle its answer
      cmd_code_out  <= command_code_word;
      cmd_write_out <= write_data_word;
      cmd_strobe_r  <= cmd_exec_request;
      if (cmd_exec_request && cmd_strobe_r) begin
        response_code_word <= cmd_data_ok ? `RIOH_RESP_OK : `RIOH_RESP_BADDATA;
        if (cmd_data_ok)
          read_data_word <= cmd_read_data;
        cmd_flag_r <= 1'b1;
      end else if (!cmd_exec_request) begin
        cmd_flag_r <= 1'b0;
      end
      // alarm reset ignores operation mode and link enable
      // alarm reset is a level, repeated every cycle the request is held
      alarm_reset_r <= alarm_clear_request;
      // run commands only when link commands are allowed
      // both run bits at once is treated as stop rather than picking one
      run_fwd_out <= link_cmd_ok && run_fwd_request && !run_rev_request;
      run_rev_out <= link_cmd_ok && run_rev_request && !run_fwd_request;
    end
  end

  // =======================================
  // word 0 of the remote input image
  //   bit 0   running forward
  //   bit 1   running reverse
  //   bit 2   terminal status 1, source from selector bits 2:0
  //   bit 3   terminal status 2, source from selector bits 5:3
  //   bit 4   terminal status 3, source from selector bits 8:6
  //   bit 5   terminal status 4, source from selector bits 11:9
  //   bit 6   terminal status 5, source from selector bits 14:12
  //   bit 7   fault relay
  //   bit 8   unused, reads zero
  //   bit 9   unused, reads zero
  //   bit 10  unused, reads zero
  //   bit 11  unused, reads zero
  //   bit 12  monitoring active
  //   bit 13  speed write done
  //   bit 14  unused, reads zero
  //   bit 15  command done
  // word 1 of the remote input image
  //   bits 9:0    unused, read zero
  //   bit 10      alarm state
  //   bit 11      station ready
  //   bits 15:12  unused, read zero
  // terminal selector codes per status bit
  //   0 speed exists, 1 speed match, 2 speed arrival,
  //   3 speed detect one, 4 drive ready, 5 to 7 constant zero
  // words are rebuilt every cycle from live state

  // remote input image; unused bits held at zero
  reg [15:0] w0_nxt;
  reg [15:0] w1_nxt;
  integer    i;
  always @* begin
    w0_nxt = 16'h0000;
    w1_nxt = 16'h0000;
    w0_nxt[`RIOH_BIT_FWD]   = motor_fwd && !motor_rev;
    w0_nxt[`RIOH_BIT_REV]   = motor_rev && !motor_fwd;
    // speed flag bit 4 is spare; drive ready feeds selector code four
    for (i = 0; i < 5; i = i + 1)
      w0_nxt[`RIOH_BIT_Y1 + i] = term_pick(terminal_function_sel[i*3 +: 3],
                                           {drive_ready, speed_flags[3:0]});
    w0_nxt[`RIOH_BIT_FAULT] = prot_tripped && output_stopped;
    w0_nxt[`RIOH_BIT_MON]   = mon_flag_r;
    w0_nxt[`RIOH_BIT_SPD]   = spd_flag_r;
    w0_nxt[`RIOH_BIT_CMD]   = cmd_flag_r;
    w1_nxt[`RIOH_BIT_ALARM] = alarm_r;
    // ready falls in the same update as the alarm flag rises
    w1_nxt[`RIOH_BIT_READY] = init_done_r && !alarm_r;
  end

  // image words are registered so the master never sees a half-updated word
  always @(posedge clk) begin
    if (!resetn) begin
      rx_word0_r <= 16'h0000;
      rx_word1_r <= 16'h0000;
    end else begin
      rx_word0_r <= w0_nxt;
      rx_word1_r <= w1_nxt;
    end
  end

endmodule

// *** rtl/rioh_regs.vh ***
// constants for the remote i/o handshake block
`ifndef RIOH_REGS_VH
`define RIOH_REGS_VH
// remote input image bit positions (word 0)
`define RIOH_BIT_FWD      4'd0
`define RIOH_BIT_REV      4'd1
`define RIOH_BIT_Y1       4'd2
`define RIOH_BIT_FAULT    4'd7
`define RIOH_BIT_MON      4'd12
`define RIOH_BIT_SPD      4'd13
`define RIOH_BIT_CMD      4'd15
// remote input image bit positions (word 1)
`define RIOH_BIT_ALARM    4'd10
`define RIOH_BIT_READY    4'd11
// terminal source selector codes
`define RIOH_SRC_EXISTS   3'h0
`define RIOH_SRC_MATCH    3'h1
`define RIOH_SRC_ARRIVAL  3'h2
`define RIOH_SRC_DETECT1  3'h3
`define RIOH_SRC_READY    3'h4
`define RIOH_SRC_ZERO     3'h5
// speed full scale
`define RIOH_SPD_MAX      16'sd20000
`define RIOH_SPD_MIN      -16'sd20000
// command source settings that disable link commands
`define RIOH_CSRC_LOCAL0  2'h0
`define RIOH_CSRC_LOCAL1  2'h1
// response codes
`define RIOH_RESP_OK      16'h0000
`define RIOH_RESP_BADDATA 16'h0001
// initial data setup time after reset
`define RIOH_INIT_NS      2000
`define RIOH_CLK_NS       40
`define RIOH_INIT_CYC     ((`RIOH_INIT_NS + `RIOH_CLK_NS - 1) / `RIOH_CLK_NS)
`endif

// *** rtl/rioh_sync.v ***
// two flip-flop synchroniser for a bundle of pin-level inputs
`timescale 1ns/1ps
module rioh_sync #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;

  // =======================================
  // first stage feeds only the second
  always @(posedge clk) begin
    if (!resetn) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// *** tb/rioh_sva.sv ***
// assertion checker for the remote i/o handshake block
`timescale 1ns/1ps
module rioh_sva (
  input wire        clk,
  input wire        resetn,
  input wire        monitor_request,
  input wire        speed_write_request,
  input wire        cmd_exec_request,
  input wire        motor_fwd,
  input wire        prot_tripped,
  input wire        output_stopped,
  input wire        alarm_raised,
  input wire        alarm_excluded,
  input wire [15:0] rx_word0_r,
  input wire [15:0] rx_word1_r
);
  // ==========
  // cycles since reset release, saturating; ready may not show before 48 of them
  logic [5:0] up_cnt_r;
  always_ff @(posedge clk) begin
    if (!resetn) up_cnt_r <= 6'h00;
    else if (up_cnt_r != 6'h3f) up_cnt_r <= up_cnt_r + 6'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // held windows cover the flag latency plus one image cycle
  sequence s_mon_on;  monitor_request [*4]; endsequence
  sequence s_mon_off; !monitor_request [*3]; endsequence
  sequence s_cmd_on;  cmd_exec_request [*4]; endsequence
  sequence s_cmd_off; !cmd_exec_request [*4]; endsequence
  AST_MON_SET: assert property (s_mon_on |-> rx_word0_r[12]) else $error("monitoring flag late");
  AST_MON_CLR: assert property (s_mon_off |-> !rx_word0_r[12]) else $error("monitoring flag stuck");
  AST_SPD_SET: assert property (speed_write_request [*3] |-> rx_word0_r[13]) else $error("speed done late");
  AST_SPD_CLR: assert property (!speed_write_request [*3] |-> !rx_word0_r[13])
    else $error("speed done stuck");
  AST_CMD_SET: assert property (s_cmd_on |-> rx_word0_r[15]) else $error("command done late");
  AST_CMD_CLR: assert property (s_cmd_off |-> !rx_word0_r[15]) else $error("command done stuck");
  AST_FWD: assert property (motor_fwd [*3] |-> rx_word0_r[0]) else $error("forward flag missing");
  AST_FAULT: assert property ((prot_tripped && output_stopped) [*3] |-> rx_word0_r[7])
    else $error("fault missing");
  AST_ALARM: assert property (alarm_raised && !alarm_excluded |-> ##2 rx_word1_r[10])
    else $error("alarm late");
  AST_RDY_DROP: assert property ($rose(rx_word1_r[10]) |-> !rx_word1_r[11]) else $error("ready with alarm");
  AST_RDY_INIT: assert property (rx_word1_r[11] |-> up_cnt_r >= 6'd48) else $error("ready too early");
  AST_UNUSED: assert property ((rx_word0_r & 16'h4f00) == 16'h0 && (rx_word1_r & 16'hf3ff) == 16'h0)
    else $error("unused image bit set");
endmodule
bind rioh_top rioh_sva i_sva (.*);

// *** tb/rioh_master.sv ***
// fieldbus master model: raises and retires the alarm-clear request
`timescale 1ns/1ps
module rioh_master (
  input  wire  clk,
  input  wire  resetn,
  input  wire  clear_want,
  input  wire  link_error,
  input  wire  hold_input_on_error_switch,
  input  wire  alarm_flag,
  output logic alarm_clear_request
);
  // ==========
  // master's copy of the image bit; with the hold switch on it freezes during a link error,
  // so a frozen copy may still show no alarm while the drive is in alarm
  logic alarm_view_r;
  always_ff @(posedge clk) begin
    if (!resetn) alarm_view_r <= 1'b0;
    else if (!(link_error && hold_input_on_error_switch)) alarm_view_r <= alarm_flag;
  end
  // drop the clear once the alarm is gone, so a later alarm is not swallowed
  always_ff @(posedge clk) begin
    if (!resetn) alarm_clear_request <= 1'b0;
    else if (clear_want && alarm_view_r) alarm_clear_request <= 1'b1;
    else if (!alarm_view_r) alarm_clear_request <= 1'b0;
  end
endmodule

// *** tb/rioh_top_tb.sv ***
// self-checking bench for the remote i/o handshake block
`timescale 1ns/1ps
module rioh_top_tb;
  // ==========
  // stimulus and observed signals
  logic clk = 1'b0;
  logic resetn, run_fwd_request, run_rev_request, monitor_request, speed_write_request, cmd_exec_request;
  logic alarm_clear_request, clear_want, motor_fwd, motor_rev, prot_tripped, output_stopped;
  logic alarm_raised, alarm_excluded, drive_ready, cmd_data_ok, link_enable_input;
  logic link_error, hold_input_on_error_switch;
  logic [15:0] monitor_code_word, speed_command_word, command_code_word, write_data_word, monitor_data, cmd_read_data;
  logic [1:0]  command_source_setting;
  logic [14:0] terminal_function_sel;
  logic [4:0]  speed_flags;
  logic [15:0] monitor_code_out, speed_ref_r, cmd_code_out, cmd_write_out, rx_word0_r, rx_word1_r;
  logic [15:0] monitored_value_word, response_code_word, read_data_word;
  logic        speed_ref_valid_r, cmd_strobe_r, alarm_reset_r, run_fwd_out, run_rev_out;
  int          fail_count = 0;
  int          checked = 0;
  rioh_top i_dut (.*);
  rioh_master i_mst (.clk(clk), .resetn(resetn), .clear_want(clear_want), .link_error(link_error),
    .hold_input_on_error_switch(hold_input_on_error_switch), .alarm_flag(rx_word1_r[10]),
    .alarm_clear_request(alarm_clear_request));
  always #20 clk = ~clk;
  // ==========
  // shared helpers; values read right at an edge are the settled ones of the edge before
  task automatic step(input int n); repeat (n) @(posedge clk); endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_ready();
    step(30);
    chk(rx_word1_r[11], 1'b0);
    step(30);
    chk(rx_word1_r[11], 1'b1);
  endtask
  task automatic t_status();
    {speed_flags, motor_fwd} <= {5'h05, 1'b1};
    step(5);
    chk(rx_word0_r[7:0], 8'h55);
    {terminal_function_sel, motor_fwd, motor_rev, prot_tripped} <= {15'h5b6d, 3'b011};
    step(5);
    chk(rx_word0_r[7:0], 8'h02);
    {terminal_function_sel, output_stopped} <= {15'h0000, 1'b1};
    step(5);
    chk(rx_word0_r[7:0], 8'hfe);
    {motor_rev, prot_tripped, output_stopped} <= 3'b000;
  endtask
  task automatic t_monitor();
    {monitor_code_word, monitor_data, monitor_request} <= {16'h0006, 16'h1234, 1'b1};
    step(5);
    chk(monitored_value_word, 16'h1234);
    chk(monitor_code_out, 16'h0006);
    chk(rx_word0_r[12], 1'b1);
    monitor_data <= 16'h5678;
    step(3);
    chk(monitored_value_word, 16'h5678);
    monitor_request <= 1'b0;
    step(4);
    chk(rx_word0_r[12], 1'b0);
  endtask
  task automatic t_speed();
    {speed_command_word, speed_write_request, run_fwd_request} <= {16'h4e20, 2'b11};
    step(5);
    chk(rx_word0_r[13], 1'b1);
    chk(speed_ref_r, 16'h4e20);
    chk(run_fwd_out, 1'b0);
    chk(speed_ref_valid_r, 1'b0);
    speed_command_word <= 16'hb1e0;
    step(3);
    chk(speed_ref_r, 16'hb1e0);
    speed_command_word <= 16'hb1df;
    step(3);
    chk(speed_ref_r, 16'hb1e0);
    {speed_write_request, command_source_setting, link_enable_input} <= 4'b0101;
    step(6);
    chk(rx_word0_r[13], 1'b0);
    chk(run_fwd_out, 1'b1);
    {run_fwd_request, run_rev_request, speed_write_request, speed_command_word} <= {3'b011, 16'h03e8};
    step(3);
    chk({run_rev_out, speed_ref_valid_r}, 2'b11);
    chk(speed_ref_r, 16'h03e8);
    {speed_write_request, command_source_setting} <= 3'b001;
    step(4);
    chk(run_rev_out, 1'b0);
    run_rev_request <= 1'b0;
  endtask
  task automatic t_cmd();
    {command_code_word, write_data_word, cmd_read_data} <= {16'h0101, 16'h00aa, 16'h0bcd};
    {cmd_data_ok, cmd_exec_request} <= 2'b11;
    step(6);
    chk(rx_word0_r[15], 1'b1);
    chk(response_code_word, 16'h0000);
    chk(read_data_word, 16'h0bcd);
    chk(cmd_write_out, 16'h00aa);
    chk(cmd_code_out, 16'h0101);
    chk(cmd_strobe_r, 1'b1);
    cmd_read_data <= 16'h0bce;
    step(4);
    chk(read_data_word, 16'h0bce);
    cmd_data_ok <= 1'b0;
    step(4);
    chk(response_code_word !== 16'h0000, 1'b1);
    cmd_exec_request <= 1'b0;
    step(5);
    chk(rx_word0_r[15], 1'b0);
    chk(cmd_strobe_r, 1'b0);
  endtask
  task automatic t_alarm();
    alarm_raised <= 1'b1;
    step(1);
    alarm_raised <= 1'b0;
    step(4);
    chk(rx_word1_r[11:10], 2'b01);
    clear_want <= 1'b1;
    step(3);
    chk(alarm_reset_r, 1'b1);
    step(5);
    chk({alarm_clear_request, rx_word1_r[10]}, 2'b00);
    {clear_want, alarm_raised, alarm_excluded} <= 3'b011;
    step(1);
    {alarm_raised, alarm_excluded} <= 2'b00;
    step(4);
    chk(rx_word1_r[10], 1'b0);
    chk(alarm_reset_r, 1'b0);
  endtask
  // ==========
  // main sequence: inputs at time zero, reset for ten cycles, then the scenarios
  initial begin
    {resetn, run_fwd_request, run_rev_request, monitor_request, speed_write_request, cmd_exec_request} = '0;
    {clear_want, motor_fwd, motor_rev, prot_tripped, output_stopped, alarm_raised, alarm_excluded} = '0;
    {cmd_data_ok, link_enable_input, command_source_setting, speed_flags} = '0;
    {monitor_code_word, speed_command_word, command_code_word, write_data_word, monitor_data, cmd_read_data} = '0;
    drive_ready = 1'b1;
    link_error = 1'b0;
    hold_input_on_error_switch = 1'b1;
    terminal_function_sel = {3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    step(10);
    resetn <= 1'b1;
    t_ready();
    t_status();
    t_monitor();
    t_speed();
    t_cmd();
    t_alarm();
    complete_run();
  end
  // watchdog: the scenarios need about 160 cycles
  initial begin
    #40000;
    fail_count++;
    complete_run();
  end
endmodule
